// ===== tb/atx_line_model.sv
// behavioural line driver model: takes each offered word after a fixed serial time
`timescale 1ns/10ps
module atx_line_model #(
  parameter int DLY = 40
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // transmit buffer side
  input wire logic [3:0] tx_valid_in,
  input wire logic [127:0] tx_word_in,
  output logic [3:0] tx_done_out
);
  logic [31:0] got[4][$];
  int cnt[4];
  // count serial time while a word is offered, then pop it with a one-cycle pulse
  always @(posedge core_clk_in or posedge reset_in) begin
    for (int c = 0; c < 4; c++) begin
      if (reset_in) begin
        cnt[c] = 0;
        tx_done_out[c] <= 1'b0;
      end else begin
        tx_done_out[c] <= 1'b0;
        if (tx_valid_in[c] && !tx_done_out[c]) begin
          cnt[c] = cnt[c] + 1;
          if (cnt[c] == DLY) begin
            got[c].push_back(tx_word_in[32*c+:32]);
            cnt[c] = 0;
            tx_done_out[c] <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ===== tb/atx_word_builder_tb_top.sv
// self-checking bench for the transmit word builder
`timescale 1ns/10ps
module atx_word_builder_tb_top;
  logic core_clk_in = 1'b0, reset_in = 1'b1, tx_go_in = 1'b0, arinc_tx_global_enable_in = 1'b0;
  logic [3:0] run_in = 4'h0, tx_valid_out, tx_done, rep_zero_in = 4'hF, rep_rollover_in = 4'h0;
  logic imm_valid_in = 1'b0, reg_rd_en_in = 1'b0, fresh_data_tx_flag_in = 1'b0, mem_rd_en_out, flag_clr_out;
  logic [1:0] imm_chan_in = 2'h0;
  logic [31:0] imm_word_in = 32'h0, w0, w2, w5;
  logic [15:0] reg_rd_addr_in = 16'h0;
  logic [14:0] mem_rd_addr_out;
  logic [7:0] mem_rd_data_in = 8'h00, reg_rd_data_out, v[4];
  logic [10:0] flag_sel_out;
  logic [127:0] tx_word_out;
  logic [7:0] ram[0:32767];
  logic fl[0:2047];
  logic [31:0] exp[4][$];
  int bad_count = 0, checks_done = 0, cyc = 0;

  atx_word_builder i_atx_word_builder (.core_clk_in(core_clk_in), .reset_in(reset_in), .tx_go_in(tx_go_in),
    .arinc_tx_global_enable_in(arinc_tx_global_enable_in), .run_in(run_in), .rep_zero_in(rep_zero_in),
    .rep_rollover_in(rep_rollover_in), .mem_rd_en_out(mem_rd_en_out), .mem_rd_addr_out(mem_rd_addr_out),
    .mem_rd_data_in(mem_rd_data_in), .flag_sel_out(flag_sel_out), .fresh_data_tx_flag_in(fresh_data_tx_flag_in),
    .flag_clr_out(flag_clr_out), .imm_valid_in(imm_valid_in), .imm_chan_in(imm_chan_in), .imm_word_in(imm_word_in),
    .reg_rd_en_in(reg_rd_en_in), .reg_rd_addr_in(reg_rd_addr_in), .reg_rd_data_out(reg_rd_data_out),
    .tx_valid_out(tx_valid_out), .tx_word_out(tx_word_out), .tx_done_in(tx_done));
  atx_line_model #(.DLY(40)) i_atx_line_model (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .tx_valid_in(tx_valid_out), .tx_word_in(tx_word_out), .tx_done_out(tx_done));

  always #5 core_clk_in = ~core_clk_in;

  // on-chip RAM and fresh-data flag store; idle data toggles so stale reads show
  always @(posedge core_clk_in) begin
    mem_rd_data_in <= mem_rd_en_out ? ram[mem_rd_addr_out] : ~mem_rd_data_in;
    fresh_data_tx_flag_in <= fl[flag_sel_out];
    if (flag_clr_out)
      fl[flag_sel_out] = 1'b0;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge core_clk_in);
    reg_rd_en_in = 1'b1;
    reg_rd_addr_in = a;
    @(negedge core_clk_in);
    reg_rd_en_in = 1'b0;
    chk({24'h0, reg_rd_data_out}, {24'h0, e});
  endtask

  task automatic imm(input logic [1:0] c, input logic [31:0] w);
    @(negedge core_clk_in);
    imm_valid_in = 1'b1;
    imm_chan_in = c;
    imm_word_in = w;
    exp[c].push_back(w);
    @(negedge core_clk_in);
    imm_valid_in = 1'b0;
  endtask

  // descriptor write into channel c table, frame p, slot s
  task automatic wd(input int c, input int p, input int s, input logic [2:0] op, input logic [4:0] ix,
                    input logic [7:0] val);
    ram['h4000 + c * 'h800 + p * 8 + s * 2] = {op, ix};
    ram['h4000 + c * 'h800 + p * 8 + s * 2 + 1] = val;
  endtask

  // wait for the line model to catch up, then compare in order
  task automatic drain();
    for (int c = 0; c < 4; c++) begin
      repeat (3000) if (i_atx_line_model.got[c].size() < exp[c].size()) @(negedge core_clk_in);
      chk(i_atx_line_model.got[c].size(), exp[c].size());
      while (exp[c].size() > 0 && i_atx_line_model.got[c].size() > 0)
        chk(i_atx_line_model.got[c].pop_front(), exp[c].pop_front());
      i_atx_line_model.got[c].delete();
      exp[c].delete();
    end
  endtask

  task automatic end_of_test();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    void'($urandom(45701));
    foreach (ram[i]) ram[i] = 8'h00;
    foreach (fl[i]) fl[i] = 1'b0;
    foreach (ram[i]) if (i < 'h4000) ram[i] = $urandom;
    // ch1 table: plain, dropped conditional, mixed sources, two abandoned, plain, end
    for (int s = 0; s < 4; s++) begin
      v[s] = $urandom;
      wd(1, 0, s, atx_pkg::OP_IMM, $urandom, v[s]);
      wd(1, 1, s, (s == 0) ? atx_pkg::OP_IMMC : atx_pkg::OP_IMM, 5'h0C, 8'h05);
      wd(1, 3, s, (s == 2) ? atx_pkg::OP_NOP : atx_pkg::OP_IMM, 5'h00, v[s]);
      wd(1, 4, s, (s == 1) ? atx_pkg::OP_END : atx_pkg::OP_IMM, 5'h00, v[s]);
      wd(1, 5, s, atx_pkg::OP_IMM, 5'h00, ~v[s]);
    end
    w0 = {v[3], v[2], v[1], v[0]};
    w5 = ~w0;
    wd(1, 2, 0, atx_pkg::OP_ARX, 5'h09, 8'h09);
    wd(1, 2, 1, atx_pkg::OP_CAN, 5'h06, 8'h04);
    wd(1, 2, 2, atx_pkg::OP_CANC, 5'h00, 8'h07);
    wd(1, 2, 3, atx_pkg::OP_ARXC, 5'h06, 8'h03);
    w2 = {ram['h20E], ram['h3070], ram['h3046], ram['h425]};
    fl['h407] = 1'b1;
    repeat (4) @(negedge core_clk_in);
    reset_in = 1'b0;
    rd(16'h800D, 8'h0F);
    rd(16'h800C, 8'h00);
    for (int g = 1; g < 3; g++) begin
      {tx_go_in, arinc_tx_global_enable_in} = g[1:0];
      imm(2'(g), $urandom);
      repeat (30) @(negedge core_clk_in);
      chk({28'h0, tx_valid_out}, 32'h0);
    end
    {tx_go_in, arinc_tx_global_enable_in} = 2'b11;
    drain();
    imm(2'h2, $urandom);
    repeat (3) @(negedge core_clk_in);
    rd(16'h800D, 8'h0F);
    imm(2'h2, $urandom);
    repeat (3) @(negedge core_clk_in);
    rd(16'h800D, 8'h0B);
    drain();
    // ch1 runs once, once more, then with a repetition rate so it waits for rollover
    for (int p = 0; p < 3; p++) begin
      rep_zero_in = (p == 2) ? 4'hD : 4'hF;
      run_in = 4'h2;
      exp[1].push_back(w0);
      if (p == 0) imm(2'h1, $urandom);
      if (p == 0) exp[1].push_back(w2);
      exp[1].push_back(w5);
      drain();
      if (p == 2) begin
        imm(2'h1, $urandom);
        drain();
        rep_rollover_in = 4'h2;
        @(negedge core_clk_in);
        rep_rollover_in = 4'h0;
        exp[1].push_back(w0);
        exp[1].push_back(w5);
        drain();
      end
      repeat (100) @(negedge core_clk_in);
      drain();
      chk({31'h0, fl['h407]}, 32'h0);
      run_in = 4'h0;
      @(negedge core_clk_in);
    end
    end_of_test();
  end
endmodule

// ===== verilog/atx_imm_hold.sv
// landing slots for host immediate words, one per transmit channel
`timescale 1ns/10ps
module atx_imm_hold (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // host immediate command
  input wire logic load_in,
  input wire logic [1:0] load_ch_in,
  input wire logic [31:0] load_word_in,
  // consumer side
  input wire logic [atx_pkg::NCH-1:0] take_in,
  output logic [atx_pkg::NCH-1:0] pend_out,
  output logic [atx_pkg::NCH*32-1:0] word_out
);
  logic [atx_pkg::NCH-1:0] load_vec;

  // one-hot channel of a host load
  assign load_vec = load_in ? ({{(atx_pkg::NCH-1){1'b0}}, 1'b1} << load_ch_in) : '0;

  // a load wins over a same-cycle take so no host word is lost
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pend_out <= '0;
      word_out <= '0;
    end else begin
      for (int c = 0; c < atx_pkg::NCH; c++) begin
        if (load_vec[c]) begin
          pend_out[c] <= 1'b1;
          word_out[c*32 +: 32] <= load_word_in;
        end else if (take_in[c]) begin
          pend_out[c] <= 1'b0;
        end
      end
    end
  end
endmodule

// ===== verilog/atx_pkg.sv
// shared constants, opcodes and helper functions for the transmit word builder
package atx_pkg;
  localparam int NCH = 4;
  localparam int TXBUF_DEPTH = 2;
  localparam logic [15:0] READY_REG_ADDR = 16'h800D;
  localparam logic [14:0] SEQ_TABLE_BASE = 15'h4000;
  localparam logic [14:0] ARX_RAM_BASE = 15'h0000;
  localparam logic [14:0] CAN_RAM_BASE = 15'h3000;
  localparam logic [7:0] SEQ_LAST_PTR = 8'hFF;
  localparam logic [1:0] LAST_SLOT = 2'h3;
  localparam logic [7:0] REG_IDLE_VALUE = 8'h00;

  // descriptor opcodes, encoded 000 to 111 in declaration order
  typedef enum logic [2:0] {
    OP_END, OP_NOP, OP_IMM, OP_IMMC, OP_ARX, OP_ARXC, OP_CAN, OP_CANC
  } atx_op_t;

  // per-channel sequencer states
  typedef enum logic [1:0] {SQ_IDLE, SQ_ACTIVE, SQ_WAIT} atx_seq_t;

  // byte address of the opcode byte (hi=0) or value byte (hi=1) of a descriptor
  function automatic logic [14:0] desc_addr(input logic [1:0] ch, input logic [7:0] ptr,
                                            input logic [1:0] slot, input logic hi);
    return SEQ_TABLE_BASE + {2'b00, ch, ptr, slot, hi};
  endfunction

  // receive RAM byte selected by an indexed or CAN descriptor
  function automatic logic [14:0] src_addr(input atx_op_t op, input logic [4:0] idx,
                                           input logic [7:0] val);
    if (op[2:1] == 2'b11) begin
      return CAN_RAM_BASE + {4'h0, val[6:0], idx[3:0]};
    end
    return ARX_RAM_BASE + {3'b000, idx[4:2], val[6:0], idx[1:0]};
  endfunction

  // fresh-data flag select: bit 10 marks a CAN block
  function automatic logic [10:0] flag_sel(input atx_op_t op, input logic [4:0] idx,
                                           input logic [7:0] val);
    if (op[2:1] == 2'b11) begin
      return {1'b1, 3'b000, val[6:0]};
    end
    return {1'b0, idx[4:2], val[6:0]};
  endfunction

  // replace one byte of the word being assembled
  function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] slot,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = w;
    r[{slot, 3'b000} +: 8] = b;
    return r;
  endfunction
endpackage

// ===== verilog/atx_push_if.sv
// per-channel word hand-off from the builder into the transmit buffers
`timescale 1ns/10ps
interface atx_push_if;
  logic [atx_pkg::NCH-1:0] valid;
  logic [31:0] word;
  logic [atx_pkg::NCH-1:0] ready;
  modport src (output valid, output word, input ready);
  modport dst (input valid, input word, output ready);
endinterface

// ===== verilog/atx_tx_buffer.sv
// double-buffered transmit word store per channel, feeding the serialisers
`timescale 1ns/10ps
module atx_tx_buffer #(
  parameter int DEPTH = atx_pkg::TXBUF_DEPTH
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // words from the builder
  atx_push_if.dst push,
  // serialiser side
  input wire logic gate_in,
  output logic [atx_pkg::NCH-1:0] tx_valid_out,
  output logic [atx_pkg::NCH*32-1:0] tx_word_out,
  input wire logic [atx_pkg::NCH-1:0] tx_done_in
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [31:0] store_reg [atx_pkg::NCH][DEPTH];
  logic [PW-1:0] rd_reg [atx_pkg::NCH];
  logic [PW-1:0] wr_reg [atx_pkg::NCH];
  logic [CW-1:0] cnt_reg [atx_pkg::NCH];
  logic [atx_pkg::NCH-1:0] push_ok;
  logic [atx_pkg::NCH-1:0] pop_ok;

  // ready while a slot is free; head word always driven, but flagged valid only while transmission is allowed
  always_comb begin
    for (int c = 0; c < atx_pkg::NCH; c++) begin
      push.ready[c] = cnt_reg[c] != CW'(DEPTH);
      push_ok[c] = push.valid[c] && cnt_reg[c] != CW'(DEPTH);
      pop_ok[c] = tx_done_in[c] && cnt_reg[c] != '0;
      tx_valid_out[c] = cnt_reg[c] != '0 && gate_in;
      tx_word_out[c*32 +: 32] = store_reg[c][rd_reg[c]];
    end
  end

  // pointers and occupancy
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int c = 0; c < atx_pkg::NCH; c++) begin
        rd_reg[c] <= '0;
        wr_reg[c] <= '0;
        cnt_reg[c] <= '0;
      end
    end else begin
      for (int c = 0; c < atx_pkg::NCH; c++) begin
        if (push_ok[c]) wr_reg[c] <= (wr_reg[c] == PW'(DEPTH - 1)) ? '0 : wr_reg[c] + PW'(1);
        if (pop_ok[c]) rd_reg[c] <= (rd_reg[c] == PW'(DEPTH - 1)) ? '0 : rd_reg[c] + PW'(1);
        if (push_ok[c] && !pop_ok[c]) cnt_reg[c] <= cnt_reg[c] + CW'(1);
        else if (pop_ok[c] && !push_ok[c]) cnt_reg[c] <= cnt_reg[c] - CW'(1);
      end
    end
  end

  // word storage, no reset needed
  always_ff @(posedge core_clk_in) begin
    for (int c = 0; c < atx_pkg::NCH; c++) begin
      if (push_ok[c]) store_reg[c][wr_reg[c]] <= push.word;
    end
  end

  for (genvar g = 0; g < atx_pkg::NCH; g++) begin : g_chk
    a_first_load: assert property (@(posedge core_clk_in) disable iff (reset_in)
      push_ok[g] && !pop_ok[g] && cnt_reg[g] == '0 |=> push.ready[g] ##1 (push.ready[g] || $past(push_ok[g])))
      else $error("ready dropped after a single word");
    a_second_load: assert property (@(posedge core_clk_in) disable iff (reset_in)
      push_ok[g] && !pop_ok[g] && cnt_reg[g] == CW'(DEPTH - 1) |=> !push.ready[g])
      else $error("ready stayed high with both slots full");
  end
endmodule

// ===== verilog/atx_word_builder.sv
// transmit word builder: sequence table walker, immediate path and ready register
`timescale 1ns/10ps
module atx_word_builder (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // transmit enables and sequencer control
  input wire logic tx_go_in,
  input wire logic arinc_tx_global_enable_in,
  input wire logic [atx_pkg::NCH-1:0] run_in,
  input wire logic [atx_pkg::NCH-1:0] rep_zero_in,
  input wire logic [atx_pkg::NCH-1:0] rep_rollover_in,
  // on-chip RAM read port, data one cycle after request
  output logic mem_rd_en_out,
  output logic [14:0] mem_rd_addr_out,
  input wire logic [7:0] mem_rd_data_in,
  // fresh-data flags, flag one cycle after select
  output logic [10:0] flag_sel_out,
  input wire logic fresh_data_tx_flag_in,
  output logic flag_clr_out,
  // host immediate transmit command
  input wire logic imm_valid_in,
  input wire logic [1:0] imm_chan_in,
  input wire logic [31:0] imm_word_in,
  // register read port
  input wire logic reg_rd_en_in,
  input wire logic [15:0] reg_rd_addr_in,
  output logic [7:0] reg_rd_data_out,
  // serial transmit side
  output logic [atx_pkg::NCH-1:0] tx_valid_out,
  output logic [atx_pkg::NCH*32-1:0] tx_word_out,
  input wire logic [atx_pkg::NCH-1:0] tx_done_in
);
  typedef enum logic [2:0] {B_IDLE, B_REQ, B_OPC, B_VAL, B_SRC, B_FIN} atx_build_t;

  atx_build_t state_reg, state_next;
  atx_pkg::atx_op_t op_reg, op_next;
  logic [1:0] ch_reg, ch_next;
  logic [1:0] slot_reg, slot_next;
  logic [4:0] idx_reg, idx_next;
  logic [7:0] val_reg, val_next;
  logic [31:0] word_reg, word_next;
  logic cond_seen_reg, cond_seen_next;
  logic any_new_reg, any_new_next;
  logic [1:0] rr_reg, rr_next;
  atx_pkg::atx_seq_t seq_state_reg [atx_pkg::NCH];
  logic [7:0] seq_ptr_reg [atx_pkg::NCH];
  logic [atx_pkg::NCH-1:0] run_prev_reg;

  logic gate;
  logic [atx_pkg::NCH-1:0] imm_pend, imm_ok, seq_ok, imm_take, buf_ready;
  logic [atx_pkg::NCH*32-1:0] imm_words;
  logic imm_found, seq_found, imm_go, seq_go;
  logic [1:0] imm_pick, seq_pick, arb_ch, pick_ch;
  logic op_end, op_nop, op_imm, op_immc, op_cond;
  logic last_slot, seq_end, seq_adv, frame_drop, frame_push;
  logic [7:0] cur_val, src_byte;

  atx_push_if push_if ();

  // opcode decode of the descriptor in hand
  assign op_end = op_reg == atx_pkg::OP_END;
  assign op_nop = op_reg == atx_pkg::OP_NOP;
  assign op_imm = op_reg == atx_pkg::OP_IMM;
  assign op_immc = op_reg == atx_pkg::OP_IMMC;
  assign op_cond = op_reg[0] && op_reg[2:1] != 2'b00; // 011, 101, 111
  assign last_slot = slot_reg == atx_pkg::LAST_SLOT;

  // transmission allowed only with the go pin and the global enable both high
  assign gate = tx_go_in && arinc_tx_global_enable_in;
  assign buf_ready = push_if.ready;
  assign imm_ok = imm_pend & buf_ready & {atx_pkg::NCH{gate}};

  // channels whose sequencer may start its next frame
  always_comb begin
    for (int c = 0; c < atx_pkg::NCH; c++) begin
      seq_ok[c] = seq_state_reg[c] == atx_pkg::SQ_ACTIVE && buf_ready[c] && gate;
    end
  end

  // round-robin pick; an immediate word whose buffer has room beats every sequence frame
  always_comb begin
    imm_found = 1'b0;
    seq_found = 1'b0;
    imm_pick = rr_reg;
    seq_pick = rr_reg;
    arb_ch = rr_reg;
    for (int k = atx_pkg::NCH - 1; k >= 0; k--) begin
      arb_ch = rr_reg + 2'(k);
      if (imm_ok[arb_ch]) begin
        imm_found = 1'b1;
        imm_pick = arb_ch;
      end
      if (seq_ok[arb_ch]) begin
        seq_found = 1'b1;
        seq_pick = arb_ch;
      end
    end
  end

  assign imm_go = state_reg == B_IDLE && imm_found;
  assign seq_go = state_reg == B_IDLE && !imm_found && seq_found;
  assign pick_ch = imm_found ? imm_pick : seq_pick;
  assign imm_take = imm_go ? ({{(atx_pkg::NCH-1){1'b0}}, 1'b1} << imm_pick) : '0;

  // frame outcome
  assign seq_end = state_reg == B_VAL && op_end && slot_reg == 2'h0;
  assign seq_adv = (state_reg == B_VAL && (op_nop || (op_end && slot_reg != 2'h0)))
                   || state_reg == B_FIN;
  assign frame_drop = cond_seen_reg && !any_new_reg;
  assign frame_push = state_reg == B_FIN && !frame_drop;

  // RAM and flag requests; the value byte is used live in the cycle it arrives
  assign cur_val = (state_reg == B_VAL) ? mem_rd_data_in : val_reg;
  assign mem_rd_en_out = state_reg == B_REQ || state_reg == B_OPC
                         || (state_reg == B_VAL && !op_end && !op_nop && !op_imm);
  assign mem_rd_addr_out = (state_reg == B_VAL)
                           ? atx_pkg::src_addr(op_reg, idx_reg, mem_rd_data_in)
                           : atx_pkg::desc_addr(ch_reg, seq_ptr_reg[ch_reg], slot_reg, state_reg == B_OPC);
  assign flag_sel_out = atx_pkg::flag_sel(op_reg, idx_reg, cur_val);
  assign flag_clr_out = state_reg == B_SRC && op_cond;
  assign src_byte = op_immc ? val_reg : mem_rd_data_in;

  // hand-off into the transmit buffers
  assign push_if.valid = imm_take | (frame_push ? ({{(atx_pkg::NCH-1){1'b0}}, 1'b1} << ch_reg) : '0);
  assign push_if.word = frame_push ? word_reg : imm_words[{imm_pick, 5'h00} +: 32];

  // builder next state: fetch opcode byte, value byte, then source byte for indexed and CAN slots
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    ch_next = ch_reg;
    slot_next = slot_reg;
    idx_next = idx_reg;
    val_next = val_reg;
    word_next = word_reg;
    cond_seen_next = cond_seen_reg;
    any_new_next = any_new_reg;
    rr_next = rr_reg;
    case (state_reg)
      B_IDLE: begin
        if (imm_go) begin
          rr_next = imm_pick + 2'h1;
        end else if (seq_go) begin
          ch_next = seq_pick;
          rr_next = seq_pick + 2'h1;
          slot_next = 2'h0;
          word_next = '0;
          cond_seen_next = 1'b0;
          any_new_next = 1'b0;
          state_next = B_REQ;
        end
      end
      B_REQ: begin
        state_next = B_OPC;
      end
      B_OPC: begin
        op_next = atx_pkg::atx_op_t'(mem_rd_data_in[7:5]);
        idx_next = mem_rd_data_in[4:0];
        state_next = B_VAL;
      end
      B_VAL: begin
        val_next = mem_rd_data_in;
        if (op_end || op_nop) begin
          state_next = B_IDLE;
        end else if (op_imm) begin
          word_next = atx_pkg::put_byte(word_reg, slot_reg, mem_rd_data_in);
          slot_next = slot_reg + 2'h1;
          state_next = last_slot ? B_FIN : B_REQ;
        end else begin
          state_next = B_SRC;
        end
      end
      B_SRC: begin
        word_next = atx_pkg::put_byte(word_reg, slot_reg, src_byte);
        if (op_cond) begin
          cond_seen_next = 1'b1;
          any_new_next = any_new_reg || fresh_data_tx_flag_in;
        end
        slot_next = slot_reg + 2'h1;
        state_next = last_slot ? B_FIN : B_REQ;
      end
      B_FIN: begin
        state_next = B_IDLE;
      end
      default: begin
        state_next = B_IDLE;
      end
    endcase
  end

  // builder registers
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= B_IDLE;
      op_reg <= atx_pkg::OP_END;
      ch_reg <= 2'h0;
      slot_reg <= 2'h0;
      idx_reg <= 5'h00;
      val_reg <= 8'h00;
      word_reg <= 32'h0000_0000;
      cond_seen_reg <= 1'b0;
      any_new_reg <= 1'b0;
      rr_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      ch_reg <= ch_next;
      slot_reg <= slot_next;
      idx_reg <= idx_next;
      val_reg <= val_next;
      word_reg <= word_next;
      cond_seen_reg <= cond_seen_next;
      any_new_reg <= any_new_next;
      rr_reg <= rr_next;
    end
  end

  // per-channel sequencer: start on run rise, end of table, wait for rollover
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      run_prev_reg <= '0;
      for (int c = 0; c < atx_pkg::NCH; c++) begin
        seq_state_reg[c] <= atx_pkg::SQ_IDLE;
        seq_ptr_reg[c] <= 8'h00;
      end
    end else begin
      run_prev_reg <= run_in;
      for (int c = 0; c < atx_pkg::NCH; c++) begin
        if (!run_in[c]) begin
          seq_state_reg[c] <= atx_pkg::SQ_IDLE;
        end else if (!run_prev_reg[c]) begin
          seq_state_reg[c] <= atx_pkg::SQ_ACTIVE;
          seq_ptr_reg[c] <= 8'h00;
        end else if (2'(c) == ch_reg && (seq_end || (seq_adv && seq_ptr_reg[c] == atx_pkg::SEQ_LAST_PTR))) begin
          seq_ptr_reg[c] <= 8'h00;
          seq_state_reg[c] <= rep_zero_in[c] ? atx_pkg::SQ_IDLE : atx_pkg::SQ_WAIT;
        end else if (2'(c) == ch_reg && seq_adv) begin
          seq_ptr_reg[c] <= seq_ptr_reg[c] + 8'h01;
        end else if (seq_state_reg[c] == atx_pkg::SQ_WAIT && rep_rollover_in[c]) begin
          seq_state_reg[c] <= atx_pkg::SQ_ACTIVE;
        end
      end
    end
  end

  // ready register read, unmapped addresses read zero
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rd_data_out <= atx_pkg::REG_IDLE_VALUE;
    end else if (reg_rd_en_in && reg_rd_addr_in == atx_pkg::READY_REG_ADDR) begin
      reg_rd_data_out <= {4'h0, buf_ready};
    end else begin
      reg_rd_data_out <= atx_pkg::REG_IDLE_VALUE;
    end
  end

  atx_imm_hold u_imm (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .load_in(imm_valid_in),
    .load_ch_in(imm_chan_in),
    .load_word_in(imm_word_in),
    .take_in(imm_take),
    .pend_out(imm_pend),
    .word_out(imm_words)
  );

  atx_tx_buffer u_buf (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .push(push_if.dst),
    .gate_in(gate),
    .tx_valid_out(tx_valid_out),
    .tx_word_out(tx_word_out),
    .tx_done_in(tx_done_in)
  );

  default clocking atx_cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  a_nop_abandon: assert property (
    state_reg == B_VAL && slot_reg != 2'h0 && (op_end || op_nop)
    |=> state_reg == B_IDLE && (push_if.valid & ~imm_take) == '0)
    else $error("word not abandoned on opcode 000/001");
  a_imm_byte: assert property (
    state_reg == B_VAL && op_imm |=> 8'(word_reg >> {$past(slot_reg), 3'b000}) == $past(mem_rd_data_in))
    else $error("immediate value byte not placed");
  a_cond_value: assert property (
    state_reg == B_SRC && op_immc |=> 8'(word_reg >> {$past(slot_reg), 3'b000}) == $past(val_reg))
    else $error("conditional value byte not placed");
  a_frame_drop: assert property (
    state_reg == B_FIN && cond_seen_reg && !any_new_reg |-> push_if.valid == '0 ##1 state_reg == B_IDLE)
    else $error("frame sent with all fresh flags clear");
  a_frame_send: assert property (
    state_reg == B_FIN && (!cond_seen_reg || any_new_reg) |-> push_if.valid[ch_reg] && push_if.word == word_reg)
    else $error("qualified frame not handed over");
  a_flag_clear: assert property (
    state_reg == B_VAL && op_cond |=> flag_clr_out && flag_sel_out == $past(flag_sel_out))
    else $error("fresh flag not cleared after evaluation");
  a_arx_index: assert property (
    state_reg == B_VAL && op_reg == atx_pkg::OP_ARX |-> mem_rd_en_out
    && mem_rd_addr_out == atx_pkg::ARX_RAM_BASE + {3'b000, idx_reg[4:2], mem_rd_data_in[6:0], idx_reg[1:0]})
    else $error("indexed receive byte address wrong");
  a_can_index: assert property (
    state_reg == B_VAL && op_reg == atx_pkg::OP_CAN |-> mem_rd_en_out
    && mem_rd_addr_out == atx_pkg::CAN_RAM_BASE + {4'h0, mem_rd_data_in[6:0], idx_reg[3:0]})
    else $error("CAN receive byte address wrong");
  a_gate_block: assert property (
    !gate |-> tx_valid_out == '0 && imm_take == '0 && !seq_go)
    else $error("transmission while disabled");
  a_ready_read: assert property (
    reg_rd_en_in && reg_rd_addr_in == atx_pkg::READY_REG_ADDR |=> reg_rd_data_out == {4'h0, $past(buf_ready)})
    else $error("ready register read wrong");
  a_imm_first: assert property (
    state_reg == B_IDLE && imm_ok != '0 |=> state_reg == B_IDLE)
    else $error("sequence frame started ahead of immediate word");
  a_end_seq: assert property (
    seq_end && run_in[ch_reg] && run_prev_reg[ch_reg] |=> seq_ptr_reg[$past(ch_reg)] == 8'h00)
    else $error("pointer not returned to zero at end of sequence");
  a_one_shot: assert property (
    seq_end && run_in[ch_reg] && run_prev_reg[ch_reg] && rep_zero_in[ch_reg]
    |=> seq_state_reg[$past(ch_reg)] == atx_pkg::SQ_IDLE)
    else $error("one-time sequence did not stop");

  c_frame_sent: cover property (frame_push);
  c_frame_dropped: cover property (state_reg == B_FIN && frame_drop);
  c_imm_sent: cover property (imm_go ##1 state_reg == B_IDLE);
  c_seq_end: cover property (seq_end);
endmodule
